// ### design/pqu_pkg.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - The unit runs its own pipeline beside the integer_pipe and never waits on it.
// - The multiplier is one signed 33x17 array: all of operand_a, 16 bits of operand_b.
// - Only operand_b picks one pass (fits in 16 bits) or two passes, with no hint.
// - One-pass multiplies issue every clock; anything right after a two-pass one stalls.
// - The divider is a sequential machine that makes one quotient bit per clock.
// - Early-in skips 23, 15 or 7 iterations for an 8, 16 or 24-bit dividend.
// - While a divide runs, any further request is stalled until its last cycle and must be held outside.
// - Pair-targeted multiplies take latency/repeat 1/1 (short) and 2/2 (long operand_b).
// - The product_to_regfile multiply takes 2/1 (short) and 3/2 (long operand_b).
// - Divides take latency/repeat 12/11, 19/18, 26/25 and 33/32 by dividend width.
// - Results land in the upper/bottom pair; move requests copy either to a register.
// - product_to_regfile writes only the low product half to its destination register.
// - mac_add adds the product to the 64-bit pair and writes the sum back.
// - mac_subtract subtracts the product from the 64-bit pair and writes it back.
//////////////////////////////////////////////////////////////////////////////////////////
package pqu_pkg;
   localparam int          DATA_W   = 32;
   localparam int          SLICE_W  = 16;
   localparam int          IDX_W    = 5;
   localparam int          CNT_W    = 6;
   localparam int          PROD_W   = 50;
   localparam logic [5:0]  SKIP_8   = 6'h17;
   localparam logic [5:0]  SKIP_16  = 6'h0F;
   localparam logic [5:0]  SKIP_24  = 6'h07;
   localparam logic [5:0]  SKIP_32  = 6'h00;
   localparam logic [5:0]  FULL_IT  = 6'h20;
   localparam logic [5:0]  LAT_8    = 6'h0C;
   localparam logic [5:0]  LAT_16   = 6'h13;
   localparam logic [5:0]  LAT_24   = 6'h1A;
   localparam logic [5:0]  LAT_32   = 6'h21;
   localparam logic [5:0]  CNT_ONE  = 6'h01;

   typedef enum logic [3:0] {
      OP_WIDENING_PRODUCT_OP_S   = 4'h0,
      OP_WIDENING_PRODUCT_OP_U   = 4'h1,
      OP_MAC_ADD_S   = 4'h2,
      OP_MAC_ADD_U   = 4'h3,
      OP_MAC_SUBTRACT_S   = 4'h4,
      OP_MAC_SUBTRACT_U   = 4'h5,
      OP_MUL_RF   = 4'h6,
      OP_DIV_S    = 4'h7,
      OP_DIV_U    = 4'h8,
      OP_MOVE_UP  = 4'h9,
      OP_MOVE_BOT = 4'hA
   } op_t;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'h0,
      DIV_ITER = 2'h1,
      DIV_HOLD = 2'h3
   } div_state_t;

   typedef struct packed {
      logic              valid;
      op_t               op;
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] b;
      logic [IDX_W-1:0]  dest;
   } mdu_req_t;

   typedef struct packed {
      logic              valid;
      logic [IDX_W-1:0]  dest;
      logic [DATA_W-1:0] data;
   } wb_t;
endpackage

// ### design/product_quotient_unit.sv
`timescale 1ns/1ns
module product_quotient_unit
   import pqu_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire mdu_req_t          i_req,
   output logic                   o_stall,
   output wb_t                    o_wb,
   output logic [DATA_W-1:0]      o_upper,
   output logic [DATA_W-1:0]      o_bottom
);

   //////////////////////////////////////////////////////////////////////////////////////
   // Request decode.
   logic              is_mul_pair;
   logic              is_mul_rf;
   logic              is_mul;
   logic              is_div;
   logic              is_move;
   logic              sgn;
   logic              b_short;
   logic              accept;

   always_comb begin
      is_mul_pair = i_req.op inside {OP_WIDENING_PRODUCT_OP_S, OP_WIDENING_PRODUCT_OP_U, OP_MAC_ADD_S, OP_MAC_ADD_U,
                                     OP_MAC_SUBTRACT_S, OP_MAC_SUBTRACT_U};
      is_mul_rf   = i_req.op == OP_MUL_RF;
      is_mul      = is_mul_pair | is_mul_rf;
      is_div      = i_req.op inside {OP_DIV_S, OP_DIV_U};
      is_move     = i_req.op inside {OP_MOVE_UP, OP_MOVE_BOT};
      sgn         = i_req.op inside {OP_WIDENING_PRODUCT_OP_S, OP_MAC_ADD_S, OP_MAC_SUBTRACT_S, OP_MUL_RF,
                                     OP_DIV_S};
      b_short     = sgn ? (i_req.b[DATA_W-1:SLICE_W] == {SLICE_W{i_req.b[SLICE_W-1]}})
                        : (i_req.b[DATA_W-1:SLICE_W] == '0);
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Multiplier passes.
   logic                      p2_q, p2_d;
   op_t                       p2_op_q, p2_op_d;
   logic [DATA_W:0]           p2_a_q, p2_a_d;
   logic [SLICE_W:0]          p2_s_q, p2_s_d;
   logic [2*DATA_W-1:0]       p2_part_q, p2_part_d;
   logic [IDX_W-1:0]          p2_dest_q, p2_dest_d;
   logic [DATA_W:0]           m_a;
   logic [SLICE_W:0]          m_s;
   logic signed [PROD_W-1:0]  pp;
   logic [2*DATA_W-1:0]       pp64;
   logic                      fin_v;
   op_t                       fin_op;
   logic [2*DATA_W-1:0]       fin_prod;
   logic [IDX_W-1:0]          fin_dest;

   always_comb begin
      p2_d      = 1'b0;
      p2_op_d   = p2_op_q;
      p2_a_d    = p2_a_q;
      p2_s_d    = p2_s_q;
      p2_part_d = p2_part_q;
      p2_dest_d = p2_dest_q;
      fin_v     = 1'b0;
      fin_op    = i_req.op;
      fin_dest  = i_req.dest;
      if (p2_q) begin
         m_a = p2_a_q;
         m_s = p2_s_q;
      end else begin
         m_a = {sgn & i_req.a[DATA_W-1], i_req.a};
         m_s = {sgn & b_short & i_req.b[SLICE_W-1], i_req.b[SLICE_W-1:0]};
      end
      pp   = $signed(m_a) * $signed(m_s);
      pp64 = {{(2*DATA_W-PROD_W){pp[PROD_W-1]}}, pp};
      fin_prod = pp64;
      if (p2_q) begin
         fin_v    = 1'b1;
         fin_op   = p2_op_q;
         fin_dest = p2_dest_q;
         fin_prod = p2_part_q + {pp64[2*DATA_W-SLICE_W-1:0], {SLICE_W{1'b0}}};
      end else if (accept & is_mul) begin
         if (b_short) begin
            fin_v = 1'b1;
         end else begin
            p2_d      = 1'b1;
            p2_op_d   = i_req.op;
            p2_a_d    = m_a;
            p2_s_d    = {sgn & i_req.b[DATA_W-1], i_req.b[DATA_W-1:SLICE_W]};
            p2_part_d = pp64;
            p2_dest_d = i_req.dest;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         p2_q      <= 1'b0;
         p2_op_q   <= OP_WIDENING_PRODUCT_OP_S;
         p2_a_q    <= '0;
         p2_s_q    <= '0;
         p2_part_q <= '0;
         p2_dest_q <= '0;
      end else begin
         p2_q      <= p2_d;
         p2_op_q   <= p2_op_d;
         p2_a_q    <= p2_a_d;
         p2_s_q    <= p2_s_d;
         p2_part_q <= p2_part_d;
         p2_dest_q <= p2_dest_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Divider.
   div_state_t         dst_q, dst_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   logic [CNT_W-1:0]   it_q, it_d;
   logic [DATA_W:0]    rem_q, rem_d;
   logic [DATA_W-1:0]  quo_q, quo_d;
   logic [DATA_W-1:0]  dvs_q, dvs_d;
   logic               qneg_q, qneg_d;
   logic               rneg_q, rneg_d;
   logic [DATA_W:0]    shl;
   logic               ge;
   logic [DATA_W:0]    rem_s;
   logic [DATA_W-1:0]  quo_s;
   logic [DATA_W-1:0]  mag_a;
   logic [DATA_W-1:0]  mag_b;
   logic [CNT_W-1:0]   skip;
   logic [CNT_W-1:0]   lat;
   logic               div_fin;
   logic [DATA_W-1:0]  div_q;
   logic [DATA_W-1:0]  div_r;

   always_comb begin
      dst_d  = dst_q;
      cnt_d  = cnt_q;
      it_d   = it_q;
      rem_d  = rem_q;
      quo_d  = quo_q;
      dvs_d  = dvs_q;
      qneg_d = qneg_q;
      rneg_d = rneg_q;
      shl    = {rem_q[DATA_W-1:0], quo_q[DATA_W-1]};
      ge     = shl >= {1'b0, dvs_q};
      rem_s  = ge ? shl - {1'b0, dvs_q} : shl;
      quo_s  = {quo_q[DATA_W-2:0], ge};
      if (dst_q == DIV_ITER) begin
         rem_d = rem_s;
         quo_d = quo_s;
         it_d  = it_q - CNT_ONE;
         if (it_q == CNT_ONE) begin
            dst_d = DIV_HOLD;
         end
      end
      div_fin = (dst_q != DIV_IDLE) && (cnt_q == CNT_ONE);
      div_q   = qneg_q ? DATA_W'(~quo_d + 1'b1) : quo_d;
      div_r   = rneg_q ? DATA_W'(~rem_d[DATA_W-1:0] + 1'b1) : rem_d[DATA_W-1:0];
      if (dst_q != DIV_IDLE) begin
         cnt_d = cnt_q - CNT_ONE;
         if (div_fin) begin
            dst_d = DIV_IDLE;
         end
      end
      mag_a = (sgn & i_req.a[DATA_W-1]) ? DATA_W'(~i_req.a + 1'b1) : i_req.a;
      mag_b = (sgn & i_req.b[DATA_W-1]) ? DATA_W'(~i_req.b + 1'b1) : i_req.b;
      if (sgn ? (i_req.a[DATA_W-1:7] == {25{i_req.a[DATA_W-1]}})
              : (i_req.a[DATA_W-1:8] == '0)) begin
         skip = SKIP_8;
         lat  = LAT_8;
      end else if (sgn ? (i_req.a[DATA_W-1:15] == {17{i_req.a[DATA_W-1]}})
                       : (i_req.a[DATA_W-1:16] == '0)) begin
         skip = SKIP_16;
         lat  = LAT_16;
      end else if (sgn ? (i_req.a[DATA_W-1:23] == {9{i_req.a[DATA_W-1]}})
                       : (i_req.a[DATA_W-1:24] == '0)) begin
         skip = SKIP_24;
         lat  = LAT_24;
      end else begin
         skip = SKIP_32;
         lat  = LAT_32;
      end
      if (accept & is_div) begin
         dst_d  = DIV_ITER;
         cnt_d  = lat - CNT_ONE;
         it_d   = FULL_IT - skip;
         rem_d  = '0;
         quo_d  = mag_a << skip;
         dvs_d  = mag_b;
         qneg_d = sgn & (i_req.a[DATA_W-1] ^ i_req.b[DATA_W-1]);
         rneg_d = sgn & i_req.a[DATA_W-1];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dst_q  <= DIV_IDLE;
         cnt_q  <= '0;
         it_q   <= '0;
         rem_q  <= '0;
         quo_q  <= '0;
         dvs_q  <= '0;
         qneg_q <= 1'b0;
         rneg_q <= 1'b0;
      end else begin
         dst_q  <= dst_d;
         cnt_q  <= cnt_d;
         it_q   <= it_d;
         rem_q  <= rem_d;
         quo_q  <= quo_d;
         dvs_q  <= dvs_d;
         qneg_q <= qneg_d;
         rneg_q <= rneg_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Issue control. Nothing from the integer_pipe holds this unit back.
   logic mrf_v_q;

   always_comb begin
      o_stall = i_req.valid & (p2_q
              | ((dst_q != DIV_IDLE) & (cnt_q > CNT_ONE))
              | (is_move & mrf_v_q));
      accept  = i_req.valid & ~o_stall;
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Result pair and register file write-back.
   logic [2*DATA_W-1:0] pair_q, pair_d;
   logic [2*DATA_W-1:0] pair_cur;
   logic                mrf_v_d;
   logic [IDX_W-1:0]    mrf_dest_q, mrf_dest_d;
   logic [DATA_W-1:0]   mrf_data_q, mrf_data_d;
   wb_t                 wb_q, wb_d;

   always_comb begin
      pair_cur   = div_fin ? {div_r, div_q} : pair_q;
      pair_d     = pair_cur;
      mrf_v_d    = 1'b0;
      mrf_dest_d = mrf_dest_q;
      mrf_data_d = mrf_data_q;
      if (fin_v) begin
         unique case (fin_op)
            OP_WIDENING_PRODUCT_OP_S, OP_WIDENING_PRODUCT_OP_U: pair_d = fin_prod;
            OP_MAC_ADD_S, OP_MAC_ADD_U: pair_d = pair_cur + fin_prod;
            OP_MAC_SUBTRACT_S, OP_MAC_SUBTRACT_U: pair_d = pair_cur - fin_prod;
            default: begin
               mrf_v_d    = 1'b1;
               mrf_dest_d = fin_dest;
               mrf_data_d = fin_prod[DATA_W-1:0];
            end
         endcase
      end
      wb_d = '0;
      if (mrf_v_q) begin
         wb_d = '{valid: 1'b1, dest: mrf_dest_q, data: mrf_data_q};
      end else if (accept & is_move) begin
         wb_d.valid = 1'b1;
         wb_d.dest  = i_req.dest;
         wb_d.data  = (i_req.op == OP_MOVE_UP) ? pair_d[2*DATA_W-1:DATA_W]
                                               : pair_d[DATA_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pair_q     <= '0;
         mrf_v_q    <= 1'b0;
         mrf_dest_q <= '0;
         mrf_data_q <= '0;
         wb_q       <= '0;
      end else begin
         pair_q     <= pair_d;
         mrf_v_q    <= mrf_v_d;
         mrf_dest_q <= mrf_dest_d;
         mrf_data_q <= mrf_data_d;
         wb_q       <= wb_d;
      end
   end

   assign o_wb     = wb_q;
   assign o_upper  = pair_q[2*DATA_W-1:DATA_W];
   assign o_bottom = pair_q[DATA_W-1:0];

endmodule // product_quotient_unit

// ### bench/pqu_sva.sv
`timescale 1ns/1ns
module pqu_sva
   import pqu_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire mdu_req_t          i_req,
   input wire logic              o_stall,
   input wire wb_t               o_wb,
   input wire logic [DATA_W-1:0] o_upper,
   input wire logic [DATA_W-1:0] o_bottom
);
   logic        acc;
   logic        sgn;
   logic        lng;
   logic [63:0] prd;
   logic [31:0] quo;
   logic [31:0] rem;
   assign acc = i_req.valid && !o_stall;
   assign sgn = i_req.op inside {OP_WIDENING_PRODUCT_OP_S, OP_MAC_ADD_S, OP_MAC_SUBTRACT_S, OP_MUL_RF};
   assign lng = sgn ? (i_req.b[31:16] != {16{i_req.b[15]}}) : (i_req.b[31:16] != 16'h0000);
   assign prd = sgn ? {{32{i_req.a[31]}}, i_req.a} * {{32{i_req.b[31]}}, i_req.b}
                    : {32'h0000_0000, i_req.a} * {32'h0000_0000, i_req.b};
   assign quo = i_req.a / i_req.b;
   assign rem = i_req.a % i_req.b;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_stall_has_request: assert property (o_stall |-> i_req.valid)
      else $error("stall without a request");
   a_long_widening_product_op_stall: assert property (acc && i_req.op <= OP_MUL_RF && lng |=>
      (!i_req.valid || o_stall)) else $error("no stall after long multiply");
   a_short_issue_rate: assert property ((acc && i_req.op <= OP_MUL_RF && !lng) ##1
      (i_req.valid && i_req.op <= OP_MAC_SUBTRACT_U) |-> !o_stall) else $error("short rate lost");
   a_short_widening_product_op_lat: assert property (acc && i_req.op == OP_WIDENING_PRODUCT_OP_S && !lng |=>
      {o_upper, o_bottom} == $past(prd)) else $error("short product wrong");
   a_long_widening_product_op_lat: assert property (acc && i_req.op == OP_WIDENING_PRODUCT_OP_U && lng |=> ##1
      {o_upper, o_bottom} == $past(prd, 2)) else $error("long product wrong");
   a_regfile_write: assert property (acc && i_req.op == OP_MUL_RF && !lng |-> ##2
      (o_wb.valid && o_wb.dest == $past(i_req.dest, 2) && o_wb.data == 32'($past(prd, 2))))
      else $error("register product wrong");
   a_move_forward: assert property (acc && i_req.op == OP_MOVE_UP |=> o_wb.valid &&
      o_wb.data == o_upper && o_wb.dest == $past(i_req.dest)) else $error("move wrong");
   a_div_short_hold: assert property (acc && i_req.op == OP_DIV_U && i_req.a[31:8] == 24'h0
      |=> (!i_req.valid || o_stall)[*8] ##1 (!i_req.valid || o_stall)[*2] ##1
      (!i_req.valid || !o_stall)) else $error("short divide stall wrong");
   a_div_short_result: assert property (acc && i_req.op == OP_DIV_U && i_req.a[31:8] == 24'h0
      && i_req.b != 32'h0 |-> ##12 (o_bottom == $past(quo, 12) && o_upper == $past(rem, 12)))
      else $error("short divide result wrong");
   a_div_full_result: assert property (acc && i_req.op == OP_DIV_U && i_req.a[31:24] != 8'h00
      && i_req.b != 32'h0 |-> ##33 (o_bottom == $past(quo, 33) && o_upper == $past(rem, 33)))
      else $error("full divide result wrong");
endmodule // pqu_sva
bind product_quotient_unit pqu_sva chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
   .o_stall(o_stall), .o_wb(o_wb), .o_upper(o_upper), .o_bottom(o_bottom));

// ### bench/int_regfile_model.sv
`timescale 1ns/1ns
module int_regfile_model
   import pqu_pkg::*;
(
   input  wire logic             i_clk,
   input  wire wb_t              i_wb,
   input  wire logic [IDX_W-1:0] i_ra,
   input  wire logic [IDX_W-1:0] i_rb,
   output logic [DATA_W-1:0]     o_rda,
   output logic [DATA_W-1:0]     o_rdb
);
   logic [DATA_W-1:0] regs_q [32];
   // One write port from the unit and two bypassed read ports.
   always_ff @(posedge i_clk) begin
      if (i_wb.valid) begin
         regs_q[i_wb.dest] <= i_wb.data;
      end
   end
   assign o_rda = (i_wb.valid && i_wb.dest == i_ra) ? i_wb.data : regs_q[i_ra];
   assign o_rdb = (i_wb.valid && i_wb.dest == i_rb) ? i_wb.data : regs_q[i_rb];
endmodule // int_regfile_model

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import pqu_pkg::*;
   typedef struct {int due; logic [63:0] val;} note_t;
   logic              i_clk = 1'b0;
   logic              i_rst_n = 1'b0;
   mdu_req_t          i_req = '0;
   logic              o_stall;
   wb_t               o_wb;
   logic [DATA_W-1:0] o_upper, o_bottom, rda, rdb, r, a;
   logic [IDX_W-1:0]  ra = 5'h06, rb = 5'h04;
   logic [31:0]       seed = 32'h0000_0578;
   logic [63:0]       pair = 64'h0;
   logic              pl = 1'b0;
   op_t               op;
   int                n_errors = 0, total_checks = 0, cyc = 0, w;
   note_t             pq[$], wq[$];
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) cyc <= cyc + 1;
   product_quotient_unit dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
      .o_stall(o_stall), .o_wb(o_wb), .o_upper(o_upper), .o_bottom(o_bottom));
   int_regfile_model rf_u (.i_clk(i_clk), .i_wb(o_wb), .i_ra(ra), .i_rb(rb),
      .o_rda(rda), .o_rdb(rdb));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic sgn(op_t o);
      return o inside {OP_WIDENING_PRODUCT_OP_S, OP_MAC_ADD_S, OP_MAC_SUBTRACT_S, OP_MUL_RF, OP_DIV_S};
   endfunction
   function automatic logic [31:0] shape(logic s, logic l, logic [31:0] x);
      if (l) return {~x[15], x[30:17], 1'b1, x[15:0]};
      return s ? {{16{x[15]}}, x[15:0]} : {16'h0000, x[15:0]};
   endfunction
   function automatic logic [31:0] dvd(logic s, int n);
      logic [31:0] x;
      x = rnd();
      x[n - 1] = 1'b1;
      if (s) x[n - 2] = 1'b0;
      x = x << (32 - n);
      return s ? 32'($signed(x) >>> (32 - n)) : x >> (32 - n);
   endfunction
   function automatic int dlat(logic s, logic [31:0] x);
      logic [31:0] m;
      for (int n = 8; n < 32; n += 8) begin
         m = s ? 32'hFFFF_FFFF << (n - 1) : 32'hFFFF_FFFF << n;
         if ((x & m) == 32'h0 || (s && (x & m) == m)) return 5 + n / 8 * 7;
      end
      return 33;
   endfunction
   task automatic compare(string what, logic [63:0] exp, logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic idle(int n);
      i_req.valid = 1'b0;
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Holds the request while stalled and notes the expected result.
   task automatic issue(op_t o, logic [31:0] x, y, logic [4:0] d, output int st);
      logic        s;
      logic        l;
      int          due;
      logic [63:0] p;
      s = sgn(o);
      l = s ? (y[31:16] !== {16{y[15]}}) : (y[31:16] !== 16'h0000);
      p = s ? {{32{x[31]}}, x} * {{32{y[31]}}, y} : {32'h0, x} * {32'h0, y};
      i_req = '{1'b1, o, x, y, d};
      st = 0;
      @(negedge i_clk);
      while (o_stall !== 1'b0) begin
         st++;
         @(negedge i_clk);
      end
      @(posedge i_clk);
      #1;
      due = cyc + l;
      if (o == OP_MUL_RF) begin
         wq.push_back('{due + 1, {27'h0, d, p[31:0]}});
      end else if (o >= OP_MOVE_UP) begin
         wq.push_back('{cyc, {27'h0, d, (o == OP_MOVE_UP) ? pair[63:32] : pair[31:0]}});
      end else begin
         if (o >= OP_DIV_S) begin
            pair = s ? {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))}
                     : {x % y, x / y};
            due = cyc + dlat(s, x) - 1;
         end else if (o <= OP_WIDENING_PRODUCT_OP_U) pair = p;
         else if (o <= OP_MAC_ADD_U) pair = pair + p;
         else pair = pair - p;
         if (pq.size() > 0 && pq[$].due == due) pq[$].val = pair;
         else pq.push_back('{due, pair});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Outputs are looked at mid-cycle, where they have settled and still stand.
   always @(negedge i_clk) begin
      if (pq.size() > 0 && pq[0].due == cyc) begin
         compare("result pair", pq[0].val, {o_upper, o_bottom});
         void'(pq.pop_front());
      end
      if (o_wb.valid === 1'b1) begin
         compare("write note", 64'(wq.size() > 0), 64'h1);
         if (wq.size() > 0) begin
            compare("write data", wq[0].val, {27'h0, o_wb.dest, o_wb.data});
            compare("write cycle", 64'(wq[0].due), 64'(cyc));
            void'(wq.pop_front());
         end
      end
   end
   always @(posedge i_clk) begin
      if (cyc == 3000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      compare("pair after reset", 64'h0, {o_upper, o_bottom});
      for (int i = 0; i < 30; i++) begin
         op = op_t'(i % 6);
         r = rnd();
         issue(op, rnd(), shape(sgn(op), r[0], rnd()), 5'h00, w);
         compare("stall cycles", 64'(pl), 64'(w));
         pl = r[0];
      end
      idle(3);
      issue(OP_MUL_RF, rnd(), shape(1'b1, 1'b0, rnd()), 5'h03, w);
      issue(OP_MUL_RF, rnd(), shape(1'b1, 1'b1, rnd()), 5'h04, w);
      compare("stall cycles", 64'h0, 64'(w));
      issue(OP_WIDENING_PRODUCT_OP_U, rnd(), rnd(), 5'h00, w);
      compare("stall cycles", 64'h1, 64'(w));
      idle(4);
      issue(OP_MOVE_UP, 32'h0, 32'h0, 5'h05, w);
      issue(OP_MOVE_BOT, 32'h0, 32'h0, 5'h06, w);
      idle(2);
      compare("register read", {32'h0, pair[31:0]}, {32'h0, rda});
      issue(OP_WIDENING_PRODUCT_OP_U, rda, rdb, 5'h00, w);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         a = dvd(i[0], 8 + i / 2 * 8);
         issue(i[0] ? OP_DIV_S : OP_DIV_U, a,
               i[0] ? {{24{r[7]}}, r[7:1], 1'b1} : {24'h0, r[7:1], 1'b1}, 5'h00, w);
         issue(OP_MOVE_BOT, 32'h0, 32'h0, 5'h07, w);
         compare("divide stall", 64'(10 + i / 2 * 7), 64'(w));
      end
      idle(40);
      complete_run();
   end
endmodule // testbench
